// ===== logic/ccs_consts.svh
// Constants for the machine-cycle sequencer
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH
`define CCS_PC_RESET    16'h0000
`define CCS_ST_RESET    16'h0000
`define CCS_ST_LGT      15
`define CCS_ST_AGT      14
`define CCS_ST_EQ       13
`define CCS_ST_C        12
`define CCS_ST_OV       11
`define CCS_ST_OP       10
`define CCS_OP_JFIRST   8'h10
`define CCS_OP_JLAST    8'h1c
`define CCS_OP_SET_IO_BIT   8'h1d
`define CCS_OP_CLEAR_IO_BIT 8'h1e
`define CCS_OP_TEST_IO_BIT  8'h1f
`define CCS_OP_SHIFT    6'h02
`define CCS_OP_IMM      9'h004
`define CCS_IMM_ADD     2'h1
`define CCS_IMM_AND     2'h2
`define CCS_IMM_OR      2'h3
`define CCS_SH_SRA      2'h0
`define CCS_SH_SRL      2'h1
`define CCS_SH_SLA      2'h2
`define CCS_SH_SRC      2'h3
`define CCS_R12_OFS     16'h0018
`define CCS_IMM_OFS     16'h0002
`define CCS_PC_STEP     16'h0002
`define CCS_PC_STEP_IMM 16'h0004
`define CCS_CYC_FETCH   4'h1
`define CCS_CYC_JCOND   4'h3
`define CCS_CYC_JDISP   4'h4
`define CCS_CYC_JEND    4'h5
`define CCS_CYC_IO_BASE 4'h4
`define CCS_CYC_IO      4'h6
`define CCS_CYC_SH_REG  4'h3
`define CCS_CYC_SH_TEST 4'h4
`define CCS_CYC_SH_R0   4'h6
`define CCS_CYC_SH_LAST 4'h8
`define CCS_CYC_IM_REG  4'h4
`define CCS_CYC_IM_OPD  4'h5
`define CCS_CYC_IM_ALU  4'h6
`define CCS_CYC_IM_WR   4'h7
`endif

// ===== logic/ccs_pkg.sv
// Types and helper functions of the machine-cycle sequencer
`include "ccs_consts.svh"
package ccs_pkg;
	typedef enum logic [2:0] {
		K_NONE, K_SET_IO_BIT, K_CLEAR_IO_BIT, K_TEST_IO_BIT, K_JUMP, K_SHIFT, K_IMM
	} ccs_kind_e;

	typedef enum logic [4:0] {
		P_IDLE  = 5'b00001,
		P_RUN   = 5'b00010,
		P_SHIFT = 5'b00100,
		P_WRITE = 5'b01000,
		P_FINAL = 5'b10000
	} ccs_phase_e;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        io_out_strobe;
		logic        io_serial_out;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ccs_bus_s;

	function automatic ccs_kind_e ccs_kind_of(input logic [15:0] w);
		ccs_kind_e k;
		k = K_NONE;
		if (w[15:8] >= `CCS_OP_JFIRST && w[15:8] <= `CCS_OP_JLAST) k = K_JUMP;
		else if (w[15:8] == `CCS_OP_SET_IO_BIT) k = K_SET_IO_BIT;
		else if (w[15:8] == `CCS_OP_CLEAR_IO_BIT) k = K_CLEAR_IO_BIT;
		else if (w[15:8] == `CCS_OP_TEST_IO_BIT) k = K_TEST_IO_BIT;
		else if (w[15:10] == `CCS_OP_SHIFT) k = K_SHIFT;
		else if (w[15:7] == `CCS_OP_IMM && w[6:5] != 2'h0) k = K_IMM;
		return k;
	endfunction : ccs_kind_of

	function automatic logic ccs_jump_taken(input logic [3:0] c, input logic [15:0] s);
		logic lgt, agt, eq, t;
		lgt = s[`CCS_ST_LGT];
		agt = s[`CCS_ST_AGT];
		eq  = s[`CCS_ST_EQ];
		case (c)
		4'h0: t = 1'b1;
		4'h1: t = !agt && !eq;
		4'h2: t = !lgt || eq;
		4'h3: t = eq;
		4'h4: t = lgt || eq;
		4'h5: t = agt;
		4'h6: t = !eq;
		4'h7: t = !s[`CCS_ST_C];
		4'h8: t = s[`CCS_ST_C];
		4'h9: t = !s[`CCS_ST_OV];
		4'ha: t = !lgt && !eq;
		4'hb: t = lgt && !eq;
		4'hc: t = s[`CCS_ST_OP];
		default: t = 1'b0;
		endcase
		return t;
	endfunction : ccs_jump_taken

	function automatic logic [15:0] ccs_cmp_flags(input logic [15:0] s, input logic [15:0] v);
		logic [15:0] r;
		r = s;
		r[`CCS_ST_LGT] = v != 16'h0000;
		r[`CCS_ST_AGT] = !v[15] && v != 16'h0000;
		r[`CCS_ST_EQ]  = v == 16'h0000;
		return r;
	endfunction : ccs_cmp_flags

	function automatic logic [15:0] ccs_disp2(input logic [15:0] ir);
		return {{7{ir[7]}}, ir[7:0], 1'b0};
	endfunction : ccs_disp2

	function automatic logic [15:0] ccs_reg_addr(input logic [15:0] wp, input logic [3:0] n);
		return wp + {11'h000, n, 1'b0};
	endfunction : ccs_reg_addr
endpackage : ccs_pkg

// ===== logic/ccs_shift_unit.sv
// One-bit shift step for the workspace register shift loop
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_shift_unit import ccs_pkg::*; #(
	parameter int WIDTH = 16
) (
	input  wire logic [1:0]       mode,
	input  wire logic [WIDTH-1:0] value,
	output logic      [WIDTH-1:0] out_value,
	output logic                  carry,
	output logic                  msb_flip
);
	if (WIDTH < 2) begin : g_check
		$error("ccs_shift_unit needs WIDTH of at least 2");
	end

	always_comb begin
		case (mode)
		`CCS_SH_SLA: begin
			out_value = {value[WIDTH-2:0], 1'b0};
			carry     = value[WIDTH-1];
		end
		`CCS_SH_SRL: begin
			out_value = {1'b0, value[WIDTH-1:1]};
			carry     = value[0];
		end
		`CCS_SH_SRC: begin
			out_value = {value[0], value[WIDTH-1:1]};
			carry     = value[0];
		end
		default: begin
			out_value = {value[WIDTH-1], value[WIDTH-1:1]};
			carry     = value[0];
		end
		endcase
		msb_flip = (mode == `CCS_SH_SLA) && (value[WIDTH-1] != value[WIDTH-2]);
	end
endmodule : ccs_shift_unit

// ===== logic/ccs_sequencer.sv
// Machine-cycle sequencer for bit I/O, jumps, shifts and immediate ops
`timescale 1ns/1ps
`include "ccs_consts.svh"
module ccs_sequencer import ccs_pkg::*; (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        START,
	input  wire logic [15:0] WP,
	input  wire logic [15:0] MEM_RDATA,
	input  wire logic        IO_SERIAL_IN,
	output ccs_bus_s         BUS,
	output logic      [15:0] INT_DATA,
	output logic      [15:0] PC,
	output logic      [15:0] ST,
	output logic             BUSY,
	output logic             DONE,
	output logic             ILLEGAL
);
	ccs_phase_e  phase, next_phase;
	ccs_kind_e   kind, next_kind;
	logic [3:0]  cyc, next_cyc;
	logic [15:0] ir, next_ir;
	logic [15:0] pc, next_pc;
	logic [15:0] st, next_st;
	logic [15:0] wreg, next_wreg;
	logic [15:0] base, next_base;
	logic [15:0] opd, next_opd;
	logic [15:0] idata, next_idata;
	logic [4:0]  cnt, next_cnt;
	logic        jtk, next_jtk;
	logic        done, next_done;
	logic        illegal, next_illegal;
	ccs_bus_s    bus, next_bus;
	logic [15:0] sh_val;
	logic        sh_carry;
	logic        sh_flip;
	logic [16:0] sum;
	logic [15:0] res;

	ccs_shift_unit #(.WIDTH(16)) u_shift (
		.mode      (ir[9:8]),
		.value     (wreg),
		.out_value (sh_val),
		.carry     (sh_carry),
		.msb_flip  (sh_flip)
	);

	always_comb begin
		next_phase   = phase;
		next_kind    = kind;
		next_cyc     = cyc;
		next_ir      = ir;
		next_pc      = pc;
		next_st      = st;
		next_wreg    = wreg;
		next_base    = base;
		next_opd     = opd;
		next_idata   = idata;
		next_cnt     = cnt;
		next_jtk     = jtk;
		next_done    = 1'b0;
		next_illegal = 1'b0;
		sum          = {1'b0, wreg} + {1'b0, opd};
		res          = sum[15:0];
		unique case (phase)
		P_IDLE: begin
			if (START) begin
				next_phase = P_RUN;
				next_cyc   = `CCS_CYC_FETCH;
			end
		end
		P_RUN: begin
			next_cyc = cyc + 4'h1;
			if (cyc == `CCS_CYC_FETCH) begin
				next_ir   = MEM_RDATA;
				next_kind = ccs_kind_of(MEM_RDATA);
				if (ccs_kind_of(MEM_RDATA) == K_NONE) begin
					next_pc      = pc + `CCS_PC_STEP;
					next_illegal = 1'b1;
					next_done    = 1'b1;
					next_phase   = P_IDLE;
				end
			end else begin
				case (kind)
				K_SET_IO_BIT, K_CLEAR_IO_BIT, K_TEST_IO_BIT: begin
					if (cyc == `CCS_CYC_IO_BASE) next_base = MEM_RDATA;
					if (cyc == `CCS_CYC_IO) begin
						if (kind == K_TEST_IO_BIT) next_st[`CCS_ST_EQ] = IO_SERIAL_IN;
						next_pc    = pc + `CCS_PC_STEP;
						next_done  = 1'b1;
						next_phase = P_IDLE;
					end
				end
				K_JUMP: begin
					if (cyc == `CCS_CYC_JCOND) begin
						next_jtk = ccs_jump_taken(ir[11:8], st);
						if (ccs_jump_taken(ir[11:8], st)) next_cyc = `CCS_CYC_JEND;
						else next_idata = ccs_disp2(ir);
					end
					if (cyc == `CCS_CYC_JEND) begin
						next_pc    = pc + `CCS_PC_STEP + (jtk ? ccs_disp2(ir) : 16'h0000);
						next_done  = 1'b1;
						next_phase = P_IDLE;
					end
				end
				K_SHIFT: begin
					if (cyc == `CCS_CYC_SH_REG) begin
						next_wreg = MEM_RDATA;
						next_cnt  = {1'b0, ir[7:4]};
					end
					if (cyc == `CCS_CYC_SH_R0)
						next_cnt = (MEM_RDATA[3:0] == 4'h0) ? 5'h10 : {1'b0, MEM_RDATA[3:0]};
					if ((cyc == `CCS_CYC_SH_TEST && cnt != 5'h00) ||
						cyc == `CCS_CYC_SH_LAST) begin
						next_phase          = P_SHIFT;
						next_st[`CCS_ST_OV] = 1'b0;
					end
				end
				K_IMM: begin
					if (cyc == `CCS_CYC_IM_REG) next_wreg = MEM_RDATA;
					if (cyc == `CCS_CYC_IM_OPD) next_opd = MEM_RDATA;
					if (cyc == `CCS_CYC_IM_ALU) begin
						case (ir[6:5])
						`CCS_IMM_AND: res = wreg & opd;
						`CCS_IMM_OR:  res = wreg | opd;
						default:      res = sum[15:0];
						endcase
						next_wreg = res;
						next_st   = ccs_cmp_flags(st, res);
						if (ir[6:5] == `CCS_IMM_ADD) begin
							next_st[`CCS_ST_C]  = sum[16];
							next_st[`CCS_ST_OV] = (wreg[15] == opd[15]) && (res[15] != wreg[15]);
						end
					end
					if (cyc == `CCS_CYC_IM_WR) begin
						next_pc    = pc + `CCS_PC_STEP_IMM;
						next_done  = 1'b1;
						next_phase = P_IDLE;
					end
				end
				default: begin
					next_done  = 1'b1;
					next_phase = P_IDLE;
				end
				endcase
			end
		end
		P_SHIFT: begin
			next_wreg          = sh_val;
			next_cnt           = cnt - 5'h01;
			next_st[`CCS_ST_C] = sh_carry;
			next_st[`CCS_ST_OV] = st[`CCS_ST_OV] | sh_flip;
			if (cnt == 5'h01) begin
				next_phase = P_WRITE;
				next_st    = ccs_cmp_flags(st, sh_val);
				next_st[`CCS_ST_C]  = sh_carry;
				next_st[`CCS_ST_OV] = st[`CCS_ST_OV] | sh_flip;
			end
		end
		P_WRITE: next_phase = P_FINAL;
		P_FINAL: begin
			next_pc    = pc + `CCS_PC_STEP;
			next_done  = 1'b1;
			next_phase = P_IDLE;
		end
		endcase

		next_bus               = bus;
		next_bus.rd            = 1'b0;
		next_bus.wr            = 1'b0;
		next_bus.io_out_strobe = 1'b0;
		next_bus.io_serial_out = 1'b0;
		if (next_phase == P_RUN && next_cyc == `CCS_CYC_FETCH) begin
			next_bus.rd   = 1'b1;
			next_bus.addr = next_pc;
		end else if (next_phase == P_RUN) begin
			case (next_kind)
			K_SET_IO_BIT, K_CLEAR_IO_BIT, K_TEST_IO_BIT: begin
				if (next_cyc == `CCS_CYC_IO_BASE) begin
					next_bus.rd   = 1'b1;
					next_bus.addr = WP + `CCS_R12_OFS;
				end
				if (next_cyc == `CCS_CYC_IO) begin
					next_bus.addr          = next_base + ccs_disp2(next_ir);
					next_bus.io_out_strobe = next_kind != K_TEST_IO_BIT;
					next_bus.io_serial_out = next_kind == K_SET_IO_BIT;
				end
			end
			K_SHIFT: begin
				if (next_cyc == `CCS_CYC_SH_REG) begin
					next_bus.rd   = 1'b1;
					next_bus.addr = ccs_reg_addr(WP, next_ir[3:0]);
				end
				if (next_cyc == `CCS_CYC_SH_R0) begin
					next_bus.rd   = 1'b1;
					next_bus.addr = WP;
				end
			end
			K_IMM: begin
				if (next_cyc == `CCS_CYC_IM_REG) begin
					next_bus.rd   = 1'b1;
					next_bus.addr = ccs_reg_addr(WP, next_ir[3:0]);
				end
				if (next_cyc == `CCS_CYC_IM_OPD) begin
					next_bus.rd   = 1'b1;
					next_bus.addr = next_pc + `CCS_IMM_OFS;
				end
				if (next_cyc == `CCS_CYC_IM_WR) begin
					next_bus.wr    = 1'b1;
					next_bus.addr  = ccs_reg_addr(WP, next_ir[3:0]);
					next_bus.wdata = next_wreg;
				end
			end
			default: ;
			endcase
		end else if (next_phase == P_WRITE) begin
			next_bus.wr    = 1'b1;
			next_bus.addr  = ccs_reg_addr(WP, next_ir[3:0]);
			next_bus.wdata = next_wreg;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase   <= P_IDLE;
			kind    <= K_NONE;
			cyc     <= 4'h0;
			ir      <= 16'h0000;
			pc      <= `CCS_PC_RESET;
			st      <= `CCS_ST_RESET;
			wreg    <= 16'h0000;
			base    <= 16'h0000;
			opd     <= 16'h0000;
			idata   <= 16'h0000;
			cnt     <= 5'h00;
			jtk     <= 1'b0;
			done    <= 1'b0;
			illegal <= 1'b0;
			bus     <= '0;
		end else begin
			phase   <= next_phase;
			kind    <= next_kind;
			cyc     <= next_cyc;
			ir      <= next_ir;
			pc      <= next_pc;
			st      <= next_st;
			wreg    <= next_wreg;
			base    <= next_base;
			opd     <= next_opd;
			idata   <= next_idata;
			cnt     <= next_cnt;
			jtk     <= next_jtk;
			done    <= next_done;
			illegal <= next_illegal;
			bus     <= next_bus;
		end
	end

	assign BUS      = bus;
	assign INT_DATA = idata;
	assign PC       = pc;
	assign ST       = st;
	assign BUSY     = phase != P_IDLE;
	assign DONE     = done;
	assign ILLEGAL  = illegal;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_bit_write_cycle: assert property (
		bus.io_out_strobe |-> phase == P_RUN && cyc == `CCS_CYC_IO && $past(cyc, 2) == 4'h4)
		else $error("output strobe outside cycle six");
	a_bit_write_level: assert property (
		bus.io_out_strobe |-> bus.io_serial_out == (kind == K_SET_IO_BIT) &&
		kind != K_TEST_IO_BIT)
		else $error("serial output level wrong");
	a_bit_address: assert property (
		(phase == P_RUN && cyc == `CCS_CYC_IO && kind != K_SHIFT && kind != K_IMM)
		|-> bus.addr == base + ccs_disp2(ir))
		else $error("bit address wrong");
	a_base_read: assert property (
		(phase == P_RUN && cyc == `CCS_CYC_IO_BASE && kind != K_JUMP && kind != K_SHIFT
		&& kind != K_IMM) |-> bus.rd && bus.addr == WP + `CCS_R12_OFS ##2 cyc == `CCS_CYC_IO)
		else $error("base register read wrong");
	a_test_copy: assert property (
		(phase == P_RUN && kind == K_TEST_IO_BIT && cyc == `CCS_CYC_IO)
		|=> st[`CCS_ST_EQ] == $past(IO_SERIAL_IN) && done)
		else $error("tested bit not copied");
	a_jump_skip: assert property (
		(phase == P_RUN && kind == K_JUMP && cyc == `CCS_CYC_JCOND)
		|=> cyc == (jtk ? `CCS_CYC_JEND : `CCS_CYC_JDISP))
		else $error("jump skip wrong");
	a_jump_disp: assert property (
		(phase == P_RUN && kind == K_JUMP && cyc == `CCS_CYC_JDISP)
		|-> idata == ccs_disp2(ir) && $stable(bus.addr) && !bus.rd)
		else $error("displacement cycle wrong");
	a_shift_reg_read: assert property (
		(phase == P_RUN && kind == K_SHIFT && cyc == `CCS_CYC_SH_REG)
		|-> bus.rd && bus.addr == ccs_reg_addr(WP, ir[3:0]))
		else $error("shift register read wrong");
	a_shift_skip: assert property (
		(phase == P_RUN && kind == K_SHIFT && cyc == `CCS_CYC_SH_TEST && cnt != 5'h00)
		|=> phase == P_SHIFT)
		else $error("shift skip wrong");
	a_count_read: assert property (
		(phase == P_RUN && kind == K_SHIFT && cyc == `CCS_CYC_SH_R0)
		|-> bus.rd && bus.addr == WP ##1 cnt != 5'h00)
		else $error("count register read wrong");
	a_shift_steps: assert property (
		(phase == P_SHIFT && cnt > 5'h01) |=> phase == P_SHIFT && cnt == $past(cnt) - 5'h01)
		else $error("shift loop count wrong");
	a_shift_flags: assert property (
		phase == P_WRITE |-> st[`CCS_ST_EQ] == (wreg == 16'h0000))
		else $error("shift flags wrong");
	a_shift_write: assert property (
		phase == P_WRITE |-> bus.wr && bus.wdata == wreg ##1 phase == P_FINAL ##1 done)
		else $error("shift write-back wrong");
	a_imm_sequence: assert property (
		(phase == P_RUN && kind == K_IMM && cyc == `CCS_CYC_IM_REG) |-> bus.rd
		##1 bus.rd && bus.addr == pc + `CCS_IMM_OFS ##1 !bus.rd ##1 bus.wr && cyc == 4'h7)
		else $error("immediate sequence wrong");
	a_alu_quiet: assert property (
		(phase == P_SHIFT || phase == P_FINAL || phase == P_IDLE)
		|-> !bus.rd && !bus.wr && !bus.io_out_strobe)
		else $error("strobe in internal cycle");

	c_bit_set: cover property (bus.io_out_strobe && bus.io_serial_out);
	c_jump_taken: cover property (phase == P_RUN && kind == K_JUMP && cyc == 4'h3 ##1 jtk);
	c_shift_zero: cover property (phase == P_RUN && kind == K_SHIFT && cyc == `CCS_CYC_SH_R0);
	c_imm_write: cover property (bus.wr && kind == K_IMM);
endmodule : ccs_sequencer

// ===== bench/ccs_far_model.sv
// Memory and bit-addressed peripheral model facing the sequencer bus
`timescale 1ns/1ps
module ccs_far_model import ccs_pkg::*; (
	input  wire logic        CLK,
	input  wire ccs_bus_s    BUS,
	output logic      [15:0] MEM_RDATA,
	output logic             IO_SERIAL_IN
);
	logic [15:0] mem [0:255];
	logic [63:0] bits = 64'h0;
	logic [15:0] last = 16'h0;

	// Released data lines show the inverse of the last word
	assign MEM_RDATA = BUS.rd ? mem[BUS.addr[8:1]] : ~last;
	assign IO_SERIAL_IN = bits[BUS.addr[6:1]];

	always @(posedge CLK) begin
		last <= MEM_RDATA;
		if (BUS.wr)
			mem[BUS.addr[8:1]] <= BUS.wdata;
		if (BUS.io_out_strobe)
			bits[BUS.addr[6:1]] <= BUS.io_serial_out;
	end
endmodule : ccs_far_model

// ===== bench/test_cpu_cycle_sequencer_io_jump_shift.sv
// Self-checking testbench of the machine-cycle sequencer
`timescale 1ns/1ps
`include "ccs_consts.svh"
module test_cpu_cycle_sequencer_io_jump_shift import ccs_pkg::*; ;
	logic        CLK, RESET_N, START, IO_SERIAL_IN, BUSY, DONE, ILLEGAL;
	logic [15:0] WP, MEM_RDATA, INT_DATA, PC, ST;
	ccs_bus_s    BUS;
	int          mismatches = 0;
	int          comparisons = 0;
	int          n;
	logic [15:0] epc, fadr, a3, a4, id4, wadr, wdat, ioadr;
	logic [31:0] rdm, wrm, iom;
	logic        ioval, ill, bsy;

	ccs_sequencer i_dut (.CLK(CLK), .RESET_N(RESET_N), .START(START), .WP(WP),
		.MEM_RDATA(MEM_RDATA), .IO_SERIAL_IN(IO_SERIAL_IN), .BUS(BUS), .INT_DATA(INT_DATA),
		.PC(PC), .ST(ST), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL));
	ccs_far_model i_mem (.CLK(CLK), .BUS(BUS), .MEM_RDATA(MEM_RDATA),
		.IO_SERIAL_IN(IO_SERIAL_IN));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	task automatic put(input logic [15:0] a, input logic [15:0] d);
		i_mem.mem[a[8:1]] = d;
	endtask : put

	// Runs one instruction at epc and records strobes per cycle
	task automatic run(input logic [15:0] ir);
		put(epc, ir);
		rdm = 32'h0;
		wrm = 32'h0;
		iom = 32'h0;
		n = 0;
		START = 1'b1;
		while (n < 31) begin
			@(negedge CLK);
			n++;
			START = 1'b0;
			if (BUS.rd)
				rdm[n] = 1'b1;
			if (BUS.wr) begin
				wrm[n] = 1'b1;
				wadr = BUS.addr;
				wdat = BUS.wdata;
			end
			if (BUS.io_out_strobe) begin
				iom[n] = 1'b1;
				ioadr = BUS.addr;
				ioval = BUS.io_serial_out;
			end
			if (n == 1) begin
				fadr = BUS.addr;
				bsy = BUSY;
			end
			if (n == 3)
				a3 = BUS.addr;
			if (n == 4) begin
				a4 = BUS.addr;
				id4 = INT_DATA;
			end
			if (DONE === 1'b1)
				break;
		end
		ill = ILLEGAL;
		chk("fetch address", fadr, epc);
		chk("busy in fetch", bsy, 1'b1);
		chk("idle at done", BUSY, 1'b0);
	endtask : run

	task automatic t_bit_write(input logic set);
		run(set ? 16'h1d05 : 16'h1e05);
		chk("bit write reads", rdm, 32'h12);
		chk("bit write strobe", iom, 32'h40);
		chk("bit write no store", wrm, 32'h0);
		chk("bit write done", n, 7);
		chk("bit write legal", ill, 1'b0);
		chk("bit address", ioadr, 16'h004a);
		chk("bit value", ioval, set);
		chk("latched bit", i_mem.bits[6'h25], set);
		epc = epc + `CCS_PC_STEP;
		chk("pc", PC, epc);
	endtask : t_bit_write

	task automatic t_bit_test(input logic b);
		run(16'h1f05);
		chk("bit test reads", rdm, 32'h12);
		chk("bit test no strobe", iom | wrm, 32'h0);
		chk("bit test done", n, 7);
		chk("status bit two", ST[13], b);
		epc = epc + `CCS_PC_STEP;
		chk("pc", PC, epc);
	endtask : t_bit_test

	task automatic t_jump(input logic [15:0] ir, input logic taken);
		logic [15:0] d;
		d = {{7{ir[7]}}, ir[7:0], 1'b0};
		run(ir);
		chk("jump reads", rdm, 32'h2);
		chk("jump no strobe", iom | wrm, 32'h0);
		chk("jump done", n, taken ? 5 : 6);
		if (!taken) begin
			chk("jump displacement", id4, d);
			chk("jump address held", a4, a3);
		end
		epc = epc + `CCS_PC_STEP + (taken ? d : 16'h0);
		chk("pc", PC, epc);
	endtask : t_jump

	task automatic t_shift_count;
		put(WP + 16'h0006, 16'h4321);
		run(16'h0943);
		chk("shift reads", rdm, 32'h0a);
		chk("shift store cycle", wrm, 32'h1 << 9);
		chk("shift done", n, 11);
		chk("shift store address", wadr, WP + 16'h0006);
		chk("shift result", wdat, 16'h0432);
		chk("shift flags", ST[15:12], 4'hc);
		epc = epc + `CCS_PC_STEP;
		chk("pc", PC, epc);
	endtask : t_shift_count

	task automatic t_shift_zero;
		put(WP, 16'h0003);
		put(WP + 16'h000a, 16'h8001);
		run(16'h0a05);
		chk("zero count reads", rdm[8:0], 9'h04a);
		chk("zero count stores", $countones(wrm), 1);
		chk("zero count store cycle", wrm, 32'h1 << 12);
		chk("zero count address", wadr, WP + 16'h000a);
		chk("zero count result", wdat, 16'h0008);
		chk("zero count flags", ST[15:13], 3'h6);
		epc = epc + `CCS_PC_STEP;
		chk("pc", PC, epc);
	endtask : t_shift_zero

	task automatic t_imm;
		logic [15:0] e [1:3];
		e[1] = 16'h100e;
		e[2] = 16'h000f;
		e[3] = 16'h0fff;
		for (int op = 1; op <= 3; op++) begin
			put(WP + 16'h0004, 16'h0f0f);
			put(epc + `CCS_IMM_OFS, 16'h00ff);
			run(16'h0202 | 16'(op << 5));
			chk("imm reads", rdm, 32'h32);
			chk("imm store cycle", wrm, 32'h80);
			chk("imm done", n, 8);
			chk("imm store address", wadr, WP + 16'h0004);
			chk("imm result", wdat, e[op]);
			epc = epc + `CCS_PC_STEP_IMM;
			chk("pc", PC, epc);
		end
	endtask : t_imm

	task automatic t_illegal;
		run(16'h0200);
		chk("illegal flag", ill, 1'b1);
		chk("illegal done", n, 2);
		chk("illegal no strobe", iom | wrm, 32'h0);
	endtask : t_illegal

	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	initial begin
		#12000;
		mismatches++;
		final_report();
	end

	initial begin
		RESET_N = 1'b0;
		START = 1'b0;
		WP = 16'h0100;
		epc = `CCS_PC_RESET;
		repeat (8) @(negedge CLK);
		chk("reset pc", PC, `CCS_PC_RESET);
		chk("reset status", ST, `CCS_ST_RESET);
		chk("reset strobes", {BUS.rd, BUS.wr, BUS.io_out_strobe, BUSY, DONE}, 32'h0);
		RESET_N = 1'b1;
		put(WP + `CCS_R12_OFS, 16'h0040);
		t_bit_write(1'b1);
		t_bit_test(1'b1);
		t_jump(16'h1303, 1'b1);
		t_bit_write(1'b0);
		t_bit_test(1'b0);
		t_jump(16'h13fe, 1'b0);
		t_jump(16'h1002, 1'b1);
		t_shift_count();
		t_shift_zero();
		t_imm();
		t_illegal();
		final_report();
	end
endmodule : test_cpu_cycle_sequencer_io_jump_shift
